// *** design/sio_pkg.sv ***
package sio_pkg;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam int          ADR_W          = 8;
    localparam logic [7:0]  CTRL_OFS       = 8'h00;
    localparam logic [7:0]  STAT_OFS       = 8'h04;
    localparam logic [7:0]  TXB_OFS        = 8'h08;
    localparam logic [7:0]  RXB_OFS        = 8'h0c;
    localparam int          CTRL_MODE_LSB  = 0;
    localparam int          CTRL_ORDER_BIT = 2;
    localparam int          CTRL_EXT_BIT   = 3;
    localparam int          CTRL_START_BIT = 4;
    localparam int          CTRL_STOP_BIT  = 5;
    localparam int          STAT_TXE_BIT   = 0;
    localparam int          STAT_RXF_BIT   = 1;
    localparam int          STAT_UND_BIT   = 2;
    localparam int          STAT_OVR_BIT   = 3;
    localparam int          STAT_ACT_BIT   = 4;
    localparam int          STAT_SHF_BIT   = 5;

    localparam logic [1:0]  MODE_TX        = 2'h0;
    localparam logic [1:0]  MODE_RX        = 2'h1;
    localparam logic [1:0]  MODE_DUP       = 2'h2;
    localparam logic [1:0]  MODE_RES       = 2'h3;
    localparam logic [2:0]  LAST_BIT       = 3'h7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS  = 25;
    localparam int          SCK_HALF_NS    = 100;
    localparam int          SCK_HALF_CYC   =
        (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          DIV_W          = 8;

    // ------------------------------------------------------------
    // States and registered state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_ARM   = 4'h2,
        ST_SHIFT = 4'h4,
        ST_WAIT  = 4'h8
    } state_t;

    typedef struct packed {
        state_t             state;
        logic [1:0]         mode;
        logic               lsb_first;
        logic               ext_clk;
        logic               start;
        logic [7:0]         tx_buf;
        logic [7:0]         rx_buf;
        logic [7:0]         tx_sh;
        logic [7:0]         rx_sh;
        logic               tx_empty;
        logic               rx_full;
        logic               tx_underrun;
        logic               rx_overrun;
        logic               xfer_active;
        logic               shift_active;
        logic [2:0]         bit_cnt;
        logic [DIV_W-1:0]   div_cnt;
        logic               sck;
        logic               sout;
        logic               irq;
        logic               irq_pend;
        logic               txe_pend;
        logic               ovr_rd;
        logic               sck_s1;
        logic               sck_s2;
        logic               sck_s3;
        logic               si_s1;
        logic               si_s2;
        logic               ack;
        logic [31:0]        dat;
    } sio_state_t;

    localparam sio_state_t RST_STATE = '{
        state:    ST_IDLE,
        tx_empty: 1'b1,
        sck:      1'b1,
        sout:     1'b1,
        sck_s1:   1'b1,
        sck_s2:   1'b1,
        sck_s3:   1'b1,
        default:  '0
    };

endpackage

// *** design/sync_serial_transfer_engine.sv ***
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sync_serial_transfer_engine #(
    parameter int SCK_HALF_CYCLES = sio_pkg::SCK_HALF_CYC
) (
    input  wire logic                     mclk_i,
    input  wire logic                     rstn_i,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [sio_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic                          wb_ack_o,
    output logic [31:0]                   wb_dat_o,
    input  wire logic                     serial_clock_i,
    output logic                          serial_clock_o,
    output logic                          serial_clock_oe_o,
    input  wire logic                     serial_in_i,
    output logic                          serial_out_o,
    output logic                          serial_irq_o
);
    import sio_pkg::*;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (SCK_HALF_CYCLES < 2 || SCK_HALF_CYCLES > 255) begin : g_chk
        $error("SCK_HALF_CYCLES must lie in 2..255");
    end

    localparam logic [DIV_W-1:0] HALF_M1    = DIV_W'(SCK_HALF_CYCLES - 1);
    localparam int               RESUME_MAX = 2 * SCK_HALF_CYCLES + 2;

    sio_state_t st;
    sio_state_t n;

    logic req;
    logic wr_txb;
    logic rd_rxb;
    logic stop_wr;
    logic txinv;
    logic rxinv;
    logic arm_ok;
    logic run_int;
    logic tc;
    logic fall_ev;
    logic rise_ev;
    logic byte_end;
    logic wait_cond;

    // ------------------------------------------------------------
    // Decode and serial edge events
    // ------------------------------------------------------------
    assign req      = wb_cyc_i & wb_stb_i & ~st.ack;
    assign wr_txb   = req & wb_we_i & (wb_adr_i == TXB_OFS);
    assign rd_rxb   = req & ~wb_we_i & (wb_adr_i == RXB_OFS);
    assign stop_wr  = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == CTRL_OFS)
                      & wb_dat_i[CTRL_STOP_BIT];
    assign txinv    = (st.mode == MODE_TX) | (st.mode == MODE_DUP);
    assign rxinv    = (st.mode == MODE_RX) | (st.mode == MODE_DUP);
    // In transmit and duplex modes the internal clock holds off until a byte is waiting to go out
    assign arm_ok   = st.start & ~(txinv & st.tx_empty);
    assign run_int  = ~st.ext_clk & (((st.state == ST_ARM) & arm_ok)
                      | (st.state == ST_SHIFT));
    assign tc       = run_int & (st.div_cnt == HALF_M1);
    assign fall_ev  = ((st.state == ST_ARM) & st.start
                       | (st.state == ST_SHIFT))
                      & (st.ext_clk ? (st.sck_s3 & ~st.sck_s2)
                                    : (tc & st.sck));
    assign rise_ev  = (st.state == ST_SHIFT)
                      & (st.ext_clk ? (~st.sck_s3 & st.sck_s2)
                                    : (tc & ~st.sck));
    assign byte_end = rise_ev & (st.bit_cnt == LAST_BIT);
    assign wait_cond = (txinv & st.tx_empty) | (rxinv & st.rx_full);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] data;
        logic [7:0] rx_new;
        data   = st.tx_sh;
        rx_new = st.lsb_first ? {st.si_s2, st.rx_sh[7:1]}
                              : {st.rx_sh[6:0], st.si_s2};
        n      = st;
        n.irq  = 1'b0;
        n.ack  = 1'b0;
        n.dat  = 32'h0;

        // Pin synchronisers
        n.sck_s1 = serial_clock_i;
        n.sck_s2 = st.sck_s1;
        n.sck_s3 = st.sck_s2;
        n.si_s1  = serial_in_i;
        n.si_s2  = st.si_s1;

        // Internal serial clock divider, idles high
        if (tc) begin
            n.div_cnt = '0;
            n.sck     = ~st.sck;
        end else if (run_int) begin
            n.div_cnt = st.div_cnt + 8'h01;
        end else begin
            n.div_cnt = '0;
            n.sck     = 1'b1;
        end

        // Bus slave, applied before serial sets so that sets win
        if (req) begin
            n.ack = 1'b1;
            case (wb_adr_i)
                CTRL_OFS: begin
                    if (wb_we_i && wb_sel_i[0]) begin
                        n.mode      = wb_dat_i[CTRL_MODE_LSB +: 2];
                        n.lsb_first = wb_dat_i[CTRL_ORDER_BIT];
                        n.ext_clk   = wb_dat_i[CTRL_EXT_BIT];
                        n.start     = wb_dat_i[CTRL_START_BIT];
                    end
                    n.dat[CTRL_MODE_LSB +: 2] = st.mode;
                    n.dat[CTRL_ORDER_BIT]     = st.lsb_first;
                    n.dat[CTRL_EXT_BIT]       = st.ext_clk;
                    n.dat[CTRL_START_BIT]     = st.start;
                end
                STAT_OFS: begin
                    if (wb_we_i && wb_sel_i[0] && wb_dat_i[STAT_OVR_BIT]) begin
                        n.rx_overrun = 1'b0;
                        n.rx_full    = 1'b0;
                        n.ovr_rd     = 1'b0;
                    end
                    n.dat[STAT_TXE_BIT] = st.tx_empty;
                    n.dat[STAT_RXF_BIT] = st.rx_full;
                    n.dat[STAT_UND_BIT] = st.tx_underrun;
                    n.dat[STAT_OVR_BIT] = st.rx_overrun;
                    n.dat[STAT_ACT_BIT] = st.xfer_active;
                    n.dat[STAT_SHF_BIT] = st.shift_active;
                end
                TXB_OFS: begin
                    if (wb_we_i) begin
                        n.tx_empty = 1'b0;
                        if (wb_sel_i[0]) begin
                            n.tx_buf = wb_dat_i[7:0];
                        end
                    end
                    n.dat[7:0] = st.tx_buf;
                end
                RXB_OFS: begin
                    if (!wb_we_i) begin
                        if (st.rx_overrun) begin
                            // Old byte first, then the byte that overran
                            n.dat[7:0] = st.ovr_rd ? st.rx_sh : st.rx_buf;
                            n.ovr_rd   = 1'b1;
                        end else begin
                            n.dat[7:0] = st.rx_buf;
                            n.rx_full  = 1'b0;
                        end
                    end else begin
                        n.dat[7:0] = st.rx_buf;
                    end
                end
                default: n.dat = 32'h0;
            endcase
        end

        // Sequencer
        case (st.state)
            ST_IDLE: begin
                n.sout = 1'b1;
                if (st.start && st.mode != MODE_RES) begin
                    n.state = ST_ARM;
                end
            end
            ST_ARM: begin
                if (!st.start) begin
                    n.state = ST_IDLE;
                end
            end
            ST_SHIFT: n.state = ST_SHIFT;
            ST_WAIT: begin
                // Automatic wait with the clock parked high
                if (!st.start) begin
                    n.state       = ST_IDLE;
                    n.xfer_active = 1'b0;
                end else if (!wait_cond) begin
                    n.state = ST_SHIFT;
                end
            end
            default: n.state = ST_IDLE;
        endcase

        // Falling edge: load and drive the next bit
        if (fall_ev) begin
            n.state        = ST_SHIFT;
            n.xfer_active  = 1'b1;
            n.shift_active = 1'b1;
            if (st.irq_pend) begin
                n.irq_pend = 1'b0;
                n.irq      = ~st.rx_overrun;
            end
            if (st.bit_cnt == 3'h0 && txinv) begin
                if (!st.tx_empty) begin
                    data       = st.tx_buf;
                    n.txe_pend = 1'b1;
                end else begin
                    n.tx_underrun = 1'b1;
                    n.irq_pend    = 1'b1;
                end
            end
            n.sout  = txinv ? (st.lsb_first ? data[0] : data[7])
                            : 1'b1;
            n.tx_sh = st.lsb_first ? {1'b0, data[7:1]} : {data[6:0], 1'b0};
        end

        // Rising edge: capture and byte completion
        if (rise_ev) begin
            if (st.txe_pend) begin
                n.tx_empty = 1'b1;
                n.txe_pend = 1'b0;
            end
            if (!st.rx_overrun) begin
                n.rx_sh = rx_new;
            end
            n.bit_cnt = st.bit_cnt + 3'h1;
            if (st.bit_cnt == LAST_BIT) begin
                n.shift_active = 1'b0;
                if (rxinv && !st.rx_overrun) begin
                    if (st.rx_full && st.ext_clk) begin
                        n.rx_overrun = 1'b1;
                        n.irq        = 1'b1;
                    end else begin
                        n.rx_buf  = rx_new;
                        n.rx_full = 1'b1;
                        n.irq     = 1'b1;
                    end
                end else if (!rxinv) begin
                    n.irq = ~st.rx_overrun;
                end
                if (!st.start) begin
                    n.state       = ST_IDLE;
                    n.xfer_active = 1'b0;
                    n.sout        = 1'b1;
                end else if (!st.ext_clk &&
                             ((txinv && n.tx_empty) ||
                              (rxinv && n.rx_full))) begin
                    n.state = ST_WAIT;
                end
            end
        end

        // Force-stop overrides everything
        if (stop_wr) begin
            n.state        = ST_IDLE;
            n.start        = 1'b0;
            n.tx_buf       = 8'h00;
            n.rx_buf       = 8'h00;
            n.tx_sh        = 8'h00;
            n.rx_sh        = 8'h00;
            n.tx_empty     = 1'b1;
            n.rx_full      = 1'b0;
            n.tx_underrun  = 1'b0;
            n.rx_overrun   = 1'b0;
            n.xfer_active  = 1'b0;
            n.shift_active = 1'b0;
            n.bit_cnt      = 3'h0;
            n.irq_pend     = 1'b0;
            n.txe_pend     = 1'b0;
            n.ovr_rd       = 1'b0;
            n.irq          = 1'b0;
            n.sck          = 1'b1;
            n.div_cnt      = '0;
        end

        // Output held high while underrun stands
        if (n.tx_underrun || n.state == ST_IDLE) begin
            n.sout = 1'b1;
        end
    end

    // State register
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= RST_STATE;
        end else begin
            st <= n;
        end
    end

    // Outputs straight from flip-flops, except the clock enable, which is ext_clk inverted
    assign wb_ack_o          = st.ack;
    assign wb_dat_o          = st.dat;
    assign serial_clock_o    = st.sck;
    assign serial_clock_oe_o = ~st.ext_clk;
    assign serial_out_o      = st.sout;
    assign serial_irq_o      = st.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    tx_clear_a: assert property (wr_txb && !stop_wr
        && !(rise_ev && st.txe_pend) |=> !st.tx_empty)
        else $error("tx buffer write left empty flag set");
    rx_clear_a: assert property (rd_rxb && !st.rx_overrun && !byte_end
        && !stop_wr |=> !st.rx_full)
        else $error("receive read left full flag set");
    underrun_pin_a: assert property (st.tx_underrun |-> serial_out_o)
        else $error("data output low during underrun");
    stop_clear_a: assert property (stop_wr |=> st.state == ST_IDLE
        && !st.start && st.bit_cnt == 3'h0 && st.tx_empty && !st.rx_full
        && !st.rx_overrun && !st.tx_underrun && !st.xfer_active)
        else $error("force-stop did not reinitialise");
    wait_high_a: assert property (st.state == ST_WAIT |-> serial_clock_o)
        else $error("serial clock low during automatic wait");
    rx_done_a: assert property (byte_end && rxinv && !st.rx_overrun
        && !(st.rx_full && st.ext_clk) && !stop_wr
        |=> st.rx_full && serial_irq_o && st.rx_buf == $past(n.rx_sh))
        else $error("completed byte not posted to receive buffer");
    ovr_quiet_a: assert property (st.rx_overrun && $past(st.rx_overrun)
        |-> !serial_irq_o)
        else $error("interrupt raised during standing overrun");
    active_rise_a: assert property ($rose(st.xfer_active)
        |-> $past(fall_ev))
        else $error("active flag rose without a falling edge");
    shift_flag_a: assert property (st.bit_cnt != 3'h0
        |-> st.shift_active)
        else $error("shift flag low inside a byte");
    resume_a: assert property (st.state == ST_WAIT && st.start && !wait_cond
        && !stop_wr |=> ##[0:RESUME_MAX] $fell(serial_clock_o))
        else $error("clock did not resume after wait release");
endmodule
`default_nettype wire

// *** dv/sio_partner_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Far-side serial peripheral: shifts out on fall, in on rise
// ------------------------------------------------------------
module sio_partner_model (
    input  wire logic       rst_ni,
    input  wire logic       sck_i,
    input  wire logic       sout_i,
    input  wire logic       lsb_i,
    input  wire logic [7:0] tx_i,
    output logic            sin_o,
    output logic            sck_o,
    output logic [7:0]      cap_o
);
    logic [2:0] n;

    // Clock source stands high outside bursts
    initial sck_o = 1'b1;

    // Capture device output on rising edges
    always @(posedge sck_i or negedge rst_ni) begin
        if (!rst_ni) cap_o <= 8'h00;
        else cap_o <= lsb_i ? {sout_i, cap_o[7:1]} : {cap_o[6:0], sout_i};
    end

    // Present next bit on falling edges
    always @(negedge sck_i or negedge rst_ni) begin
        if (!rst_ni) begin
            n     <= 3'h0;
            sin_o <= 1'b0;
        end else begin
            sin_o <= lsb_i ? tx_i[n] : tx_i[3'h7 - n];
            n     <= n + 3'h1;
        end
    end

    // External clock pulses, 200 ns period
    // Offset keeps pin edges clear of the system clock's rising edges
    task automatic burst(input int k);
        #5;
        repeat (k) begin
            #100 sck_o = 1'b0;
            #100 sck_o = 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// *** dv/sync_serial_transfer_engine_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module sync_serial_transfer_engine_test;
    import sio_pkg::*;
    logic        mclk_i, rstn_i, cyc, stb, we, prst_n, lsb, ok;
    logic [7:0]  adr, q, ptx;
    logic [31:0] dat;
    wire logic   ack, sck_o, sck_oe, sout, irq, sin, psck, sck_w;
    wire logic [31:0] rdat;
    wire logic [7:0]  pcap;
    int          num_errors, tests_run, irqs, k;

    // Pin level from whichever side drives the clock
    assign sck_w = sck_oe ? sck_o : psck;

    sync_serial_transfer_engine #(.SCK_HALF_CYCLES(4)) dut_u (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat),
        .wb_ack_o(ack), .wb_dat_o(rdat), .serial_clock_i(sck_w),
        .serial_clock_o(sck_o), .serial_clock_oe_o(sck_oe),
        .serial_in_i(sin), .serial_out_o(sout), .serial_irq_o(irq));

    sio_partner_model p_u (.rst_ni(prst_n), .sck_i(sck_w), .sout_i(sout),
        .lsb_i(lsb), .tx_i(ptx), .sin_o(sin), .sck_o(psck), .cap_o(pcap));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    // Interrupt pulse counter
    always @(posedge mclk_i) if (irq === 1'b1) irqs++;

    task automatic check(input string nm, input logic [7:0] got,
                         input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Classic single cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d};
        do begin
            @(posedge mclk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED wb_ack expected 1 seen %b", ack);
        end
        q = rdat[7:0];
        cyc <= 1'b0; stb <= 1'b0;
    endtask

    task automatic wait_irq(input int t);
        int n;
        n = 0;
        while (irqs < t && n < 4000) begin
            @(posedge mclk_i);
            n++;
        end
    endtask

    // Clock must stay high for several serial periods
    task automatic parked;
        ok = 1'b1;
        repeat (24) begin
            @(posedge mclk_i);
            if (sck_o !== 1'b1) ok = 1'b0;
        end
    endtask

    task automatic stop;
        wb(1'b1, CTRL_OFS, 8'h20);
        wb(1'b0, STAT_OFS, 8'h00);
        check("stat_stop", q, 8'h01);
        prst_n <= 1'b0;
        @(posedge mclk_i);
        prst_n <= 1'b1;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_tx;
        wb(1'b1, TXB_OFS, 8'ha5);
        wb(1'b0, STAT_OFS, 8'h00);
        check("stat_rst", q, 8'h00);
        k = irqs;
        wb(1'b1, CTRL_OFS, 8'h10);
        repeat (16) @(posedge mclk_i);
        wb(1'b1, TXB_OFS, 8'h3c);
        wait_irq(k + 2);
        check("irqs_tx", 8'(irqs - k), 8'h02);
        check("tx_cap", pcap, 8'h3c);
        parked;
        check("tx_park", {7'h0, ok}, 8'h01);
        wb(1'b0, STAT_OFS, 8'h00);
        check("tx_stat", q & 8'h21, 8'h01);
        wb(1'b1, CTRL_OFS, 8'h00);
        wb(1'b0, STAT_OFS, 8'h00);
        check("tx_end", {q[4], 6'h0, sout}, 8'h01);
        stop;
    endtask

    task automatic t_rx;
        lsb <= 1'b1; ptx <= 8'h96;
        k = irqs;
        wb(1'b1, CTRL_OFS, 8'h15);
        wait_irq(k + 1);
        parked;
        check("rx_park", {7'h0, ok}, 8'h01);
        wb(1'b0, STAT_OFS, 8'h00);
        check("rx_full", q & 8'h02, 8'h02);
        wb(1'b0, RXB_OFS, 8'h00);
        check("rx_data", q, 8'h96);
        wb(1'b0, STAT_OFS, 8'h00);
        check("rx_clr", q & 8'h02, 8'h00);
        stop;
    endtask

    task automatic t_dup;
        lsb <= 1'b0; ptx <= 8'h5a;
        wb(1'b1, TXB_OFS, 8'hc3);
        k = irqs;
        wb(1'b1, CTRL_OFS, 8'h12);
        wait_irq(k + 1);
        wb(1'b0, STAT_OFS, 8'h00);
        check("dup_stat", q & 8'h03, 8'h03);
        wb(1'b0, RXB_OFS, 8'h00);
        check("dup_rx", q, 8'h5a);
        check("dup_tx", pcap, 8'hc3);
        parked;
        check("dup_park", {7'h0, ok}, 8'h01);
        stop;
    endtask

    task automatic t_under;
        k = irqs;
        wb(1'b1, CTRL_OFS, 8'h18);
        p_u.burst(1);
        repeat (8) @(posedge mclk_i);
        wb(1'b0, STAT_OFS, 8'h00);
        check("und_flag", q & 8'h04, 8'h04);
        check("und_out", {7'h0, sout}, 8'h01);
        p_u.burst(1);
        repeat (8) @(posedge mclk_i);
        check("und_irq", 8'(irqs - k), 8'h01);
        p_u.burst(6);
        check("und_out2", {7'h0, sout}, 8'h01);
        stop;
    endtask

    // External duplex single byte, start cleared before the last shift
    task automatic t_xdup;
        lsb <= 1'b0; ptx <= 8'h69;
        wb(1'b1, TXB_OFS, 8'h81);
        wb(1'b1, CTRL_OFS, 8'h1a);
        p_u.burst(7);
        wb(1'b1, CTRL_OFS, 8'h0a);
        p_u.burst(1);
        repeat (8) @(posedge mclk_i);
        wb(1'b0, STAT_OFS, 8'h00);
        check("xdup_stat", q & 8'h33, 8'h03);
        wb(1'b0, RXB_OFS, 8'h00);
        check("xdup_rx", q, 8'h69);
        check("xdup_tx", pcap, 8'h81);
        stop;
    endtask

    task automatic wrap_up;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        rstn_i = 1'b0; prst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
        adr = 8'h00; dat = 32'h0; lsb = 1'b0; ptx = 8'h00;
        num_errors = 0; tests_run = 0; irqs = 0;
        repeat (8) @(posedge mclk_i);
        rstn_i <= 1'b1; prst_n <= 1'b1;
        wb(1'b0, STAT_OFS, 8'h00);
        check("stat_init", q, 8'h01);
        t_tx;
        t_rx;
        t_dup;
        t_under;
        t_xdup;
        wrap_up;
    end

    initial begin
        #400000;
        num_errors++;
        wrap_up;
    end
endmodule
`default_nettype wire
